//--- verilog/led_pkg.sv
// Shared constants and types for the status lamp driver
`default_nettype none
package led_pkg;
	// Register byte offsets
	localparam logic [7:0] COND_OFF     = 8'h00;
	localparam logic [7:0] IN_ERR_OFF   = 8'h04;
	localparam logic [7:0] OUT_CTL_OFF  = 8'h08;
	localparam logic [7:0] STATUS_OFF   = 8'h0c;
	localparam logic [7:0] IRQ_STAT_OFF = 8'h10;
	localparam logic [7:0] IRQ_MASK_OFF = 8'h14;
	// Condition register bit positions
	localparam int COND_RUN       = 0;
	localparam int COND_SUPPLY_OK = 1;
	localparam int COND_WINDOW_OK = 2;
	localparam int COND_CFG_BAD   = 3;
	localparam int COND_CRIT_HERE = 4;
	localparam int COND_CRIT_AWAY = 5;
	// Interrupt status bit positions
	localparam int IRQ_CRIT   = 0;
	localparam int IRQ_REPAIR = 1;
	localparam int IRQ_SUPPLY = 2;
	// Field widths and reset values
	localparam int N_IN   = 8;
	localparam int N_OUT  = 4;
	localparam int COND_W = 6;
	localparam int IRQ_W  = 3;
	localparam logic [COND_W-1:0] COND_RST = 6'h00;
	// Flash timebase: a quarter of the 1 Hz period is half of the 2 Hz period
	localparam int CLK_PERIOD_NS   = 10;
	localparam int FLASH_QUARTER_MS = 250;
	localparam int QCNT_W = 25;
	localparam logic [QCNT_W-1:0] QUARTER_CYCLES =
		QCNT_W'(FLASH_QUARTER_MS * 1000000 / CLK_PERIOD_NS);
	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Module state lamp modes
	typedef enum logic [2:0] {
		MS_DARK      = 3'b000,
		MS_RED_FAST  = 3'b001,
		MS_RED       = 3'b010,
		MS_RED_SLOW  = 3'b011,
		MS_ALTERNATE = 3'b100,
		MS_GREEN_FL  = 3'b101,
		MS_GREEN     = 3'b110
	} ms_mode_t;
endpackage
`default_nettype wire

//--- verilog/flash_if.sv
// Shared flash phases passed from the timebase to the lamp logic
`timescale 1ns/1ps
`default_nettype none
interface flash_if;
	logic blink_1hz;	// High during the red phase of the module lamp
	logic blink_2hz;	// Fast blink, edges aligned to blink_1hz
	modport src (output blink_1hz, output blink_2hz);
	modport snk (input blink_1hz, input blink_2hz);
endinterface
`default_nettype wire

//--- verilog/flash_timebase.sv
// Single divider producing the 1 Hz and 2 Hz blink phases
`timescale 1ns/1ps
`default_nettype none
module flash_timebase #(
	parameter logic [led_pkg::QCNT_W-1:0] QUARTER = led_pkg::QUARTER_CYCLES
) (
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Blink phases
	flash_if.src      fl
);
	logic [led_pkg::QCNT_W-1:0] cnt_ff;	// Quarter period counter
	logic                       tick;	// One-cycle enable each quarter
	logic                       half_ff;	// Which quarter of the 1 Hz half
	logic                       b1_ff;
	logic                       b2_ff;

	assign tick = (cnt_ff == QUARTER - 1'b1);
	assign fl.blink_1hz = b1_ff;
	assign fl.blink_2hz = b2_ff;

	// Both rates come from one counter so their edges never drift apart
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_ff  <= '0;
			half_ff <= 1'b0;
			b1_ff   <= 1'b0;
			b2_ff   <= 1'b0;
		end else begin
			cnt_ff <= tick ? '0 : cnt_ff + 1'b1;
			if (tick) begin
				b2_ff   <= ~b2_ff;
				half_ff <= ~half_ff;
				// 1 Hz toggles every second quarter, giving 50 percent duty
				if (half_ff) begin
					b1_ff <= ~b1_ff;
				end
			end
		end
	end
endmodule
`default_nettype wire

//--- verilog/lamp_cell.sv
// Green lamp decision for one input or output channel
`timescale 1ns/1ps
`default_nettype none
module lamp_cell #(
	parameter bit IS_OUTPUT = 1'b0
) (
	// Channel condition
	input  wire logic level,
	input  wire logic err,
	// Blink phases
	flash_if.snk      fl,
	// Lamp drive, combinational
	output logic      green
);
	logic sync_blink;	// Lit while the module lamp is red
	logic anti_blink;	// Lit while the module lamp is not red

	assign sync_blink = fl.blink_1hz;
	assign anti_blink = ~fl.blink_1hz;

	// Outputs: test error blinks with red, else follows drive
	// Inputs: low with error blinks with red, high with error against it
	// Without error the lamp is simply the terminal level
	assign green = !err     ? level :
	               IS_OUTPUT ? sync_blink :
	               level     ? anti_blink : sync_blink;
endmodule
`default_nettype wire

//--- verilog/status_led_driver.sv
// Status lamp driver with AXI4-Lite registers
// Functional notes
// - Supply out of range: module lamp dark
// - Repairable error: red/green alternate at 1 Hz
// - Stop or supply window bad: green 1 Hz
// - Steady green only running with good supply
// - Local critical error: stop, outputs off, red 2 Hz
// - Input low, no error: lamp dark
// - Input high, no error: lamp green
// - Low input with error: blink with red
// - High input with error: blink against red
// - Output test error: blink with red
// - Output off, no error: lamp dark
//
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module status_led_driver #(
	parameter logic [led_pkg::QCNT_W-1:0] QUARTER = led_pkg::QUARTER_CYCLES
) (
	// Clock and reset
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	// AXI4-Lite write address and data
	input  wire logic [7:0]                awaddr,
	input  wire logic                      awvalid,
	output logic                           awready,
	input  wire logic [31:0]               wdata,
	input  wire logic [3:0]                wstrb,
	input  wire logic                      wvalid,
	output logic                           wready,
	// AXI4-Lite write response
	output logic [1:0]                     bresp,
	output logic                           bvalid,
	input  wire logic                      bready,
	// AXI4-Lite read
	input  wire logic [7:0]                araddr,
	input  wire logic                      arvalid,
	output logic                           arready,
	output logic [31:0]                    rdata,
	output logic [1:0]                     rresp,
	output logic                           rvalid,
	input  wire logic                      rready,
	// Input terminal levels, asynchronous
	input  wire logic [led_pkg::N_IN-1:0]  in_level,
	// Output channel drive
	output logic [led_pkg::N_OUT-1:0]      out_drive,
	// Lamps
	output logic                           ms_red,
	output logic                           ms_green,
	output logic [led_pkg::N_IN-1:0]       in_lamp,
	output logic [led_pkg::N_OUT-1:0]      out_lamp,
	// Interrupt, level
	output logic                           irq
);
	flash_if fl ();	// Shared blink phases

	// Software written registers
	logic [led_pkg::COND_W-1:0] cond_ff;	// Module conditions
	logic [led_pkg::N_IN-1:0]   in_err_ff;	// Repairable error per input
	logic [led_pkg::N_OUT-1:0]  out_cmd_ff;	// Requested output state
	logic [led_pkg::N_OUT-1:0]  out_terr_ff;	// Test error per output
	logic [led_pkg::IRQ_W-1:0]  irq_stat_ff;	// Sticky events
	logic [led_pkg::IRQ_W-1:0]  irq_mask_ff;	// One enables an event
	// Input synchroniser
	logic [led_pkg::N_IN-1:0]   in_meta_ff;	// First stage, read by second only
	logic [led_pkg::N_IN-1:0]   in_sync_ff;
	// Lamp and drive registers
	led_pkg::ms_mode_t          ms_mode_ff;
	logic                       ms_red_ff;
	logic                       ms_green_ff;
	logic [led_pkg::N_IN-1:0]   in_lamp_ff;
	logic [led_pkg::N_OUT-1:0]  out_lamp_ff;
	logic [led_pkg::N_OUT-1:0]  out_drive_ff;
	logic                       irq_ff;
	// Event history for edge detection
	logic                       crit_d_ff;
	logic                       repair_d_ff;
	logic                       supply_d_ff;
	// Bus state
	logic                       aw_held_ff;	// Address taken, waiting for data
	logic                       w_held_ff;	// Data taken, waiting for address
	logic [7:0]                 aw_addr_ff;
	logic [31:0]                w_data_ff;
	logic [3:0]                 w_strb_ff;
	logic                       awready_ff;
	logic                       wready_ff;
	logic                       bvalid_ff;
	logic [1:0]                 bresp_ff;
	logic                       arready_ff;
	logic                       rvalid_ff;
	logic [31:0]                rdata_ff;
	logic [1:0]                 rresp_ff;

	// Decoded conditions
	wire supply_ok = cond_ff[led_pkg::COND_SUPPLY_OK];
	wire window_ok = cond_ff[led_pkg::COND_WINDOW_OK];
	wire running   = cond_ff[led_pkg::COND_RUN];
	wire cfg_bad   = cond_ff[led_pkg::COND_CFG_BAD];
	wire crit_here = cond_ff[led_pkg::COND_CRIT_HERE];
	wire crit_away = cond_ff[led_pkg::COND_CRIT_AWAY];
	wire app_stop  = crit_here | crit_away;
	wire repair    = (|in_err_ff) | (|out_terr_ff);

	// Shared timebase
	flash_timebase #(.QUARTER(QUARTER)) u_tb (
		.aclk    (aclk),
		.aresetn (aresetn),
		.fl      (fl)
	);

	// Module lamp mode, highest priority first
	led_pkg::ms_mode_t nxt_ms_mode;
	assign nxt_ms_mode = !supply_ok             ? led_pkg::MS_DARK :
	                     crit_here              ? led_pkg::MS_RED_FAST :
	                     crit_away              ? led_pkg::MS_RED :
	                     cfg_bad                ? led_pkg::MS_RED_SLOW :
	                     repair                 ? led_pkg::MS_ALTERNATE :
	                     (!running | !window_ok) ? led_pkg::MS_GREEN_FL :
	                     led_pkg::MS_GREEN;

	// Colour selection per mode
	logic nxt_ms_red;
	logic nxt_ms_green;
	always_comb begin
		nxt_ms_red   = 1'b0;
		nxt_ms_green = 1'b0;
		unique case (nxt_ms_mode)
			led_pkg::MS_DARK: begin
				nxt_ms_red   = 1'b0;	// Dark while supply is bad
			end
			led_pkg::MS_RED_FAST: begin
				nxt_ms_red   = fl.blink_2hz;
			end
			led_pkg::MS_RED: begin
				nxt_ms_red   = 1'b1;
			end
			led_pkg::MS_RED_SLOW: begin
				nxt_ms_red   = fl.blink_1hz;
			end
			led_pkg::MS_ALTERNATE: begin
				nxt_ms_red   = fl.blink_1hz;
				nxt_ms_green = ~fl.blink_1hz;
			end
			led_pkg::MS_GREEN_FL: begin
				nxt_ms_green = fl.blink_1hz;
			end
			led_pkg::MS_GREEN: begin
				nxt_ms_green = 1'b1;
			end
			default: begin
				nxt_ms_red   = 1'b0;	// Codes 3'b111 never selected
			end
		endcase
	end

	// Channel lamps, one cell per channel
	logic [led_pkg::N_IN-1:0]  nxt_in_lamp;
	logic [led_pkg::N_OUT-1:0] nxt_out_lamp;
	logic [led_pkg::N_OUT-1:0] nxt_out_drive;
	// A critical error anywhere forces every output off
	assign nxt_out_drive = app_stop ? '0 : out_cmd_ff;
	genvar gi;
	generate
		for (gi = 0; gi < led_pkg::N_IN; gi++) begin : g_in
			lamp_cell #(.IS_OUTPUT(1'b0)) u_cell (
				.level (in_sync_ff[gi]),
				.err   (in_err_ff[gi]),
				.fl    (fl),
				.green (nxt_in_lamp[gi])
			);
		end
		for (gi = 0; gi < led_pkg::N_OUT; gi++) begin : g_out
			lamp_cell #(.IS_OUTPUT(1'b1)) u_cell (
				.level (out_drive_ff[gi]),
				.err   (out_terr_ff[gi]),
				.fl    (fl),
				.green (nxt_out_lamp[gi])
			);
		end
	endgenerate

	// Two flops on the asynchronous input pins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			in_meta_ff <= '0;
			in_sync_ff <= '0;
		end else begin
			in_meta_ff <= in_level;
			in_sync_ff <= in_meta_ff;
		end
	end

	// Lamp and drive outputs, registered so the pins never glitch
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ms_mode_ff   <= led_pkg::MS_DARK;
			ms_red_ff    <= 1'b0;
			ms_green_ff  <= 1'b0;
			in_lamp_ff   <= '0;
			out_lamp_ff  <= '0;
			out_drive_ff <= '0;
		end else begin
			ms_mode_ff   <= nxt_ms_mode;
			ms_red_ff    <= nxt_ms_red;
			ms_green_ff  <= nxt_ms_green;
			in_lamp_ff   <= nxt_in_lamp;
			out_lamp_ff  <= nxt_out_lamp;
			out_drive_ff <= nxt_out_drive;
		end
	end

	// Events: a new critical error, a new repairable error, supply loss
	wire [led_pkg::IRQ_W-1:0] irq_evt = {
		supply_d_ff & ~supply_ok,
		~repair_d_ff & repair,
		~crit_d_ff & app_stop
	};

	// Bus decode
	wire wr_fire  = aw_held_ff & w_held_ff & ~bvalid_ff;
	wire ar_fire  = arvalid & arready_ff;
	wire [31:0] wmask = {{8{w_strb_ff[3]}}, {8{w_strb_ff[2]}},
	                     {8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};
	wire [31:0] wbits = w_data_ff & wmask;
	wire wr_cond  = wr_fire & (aw_addr_ff == led_pkg::COND_OFF);
	wire wr_inerr = wr_fire & (aw_addr_ff == led_pkg::IN_ERR_OFF);
	wire wr_outc  = wr_fire & (aw_addr_ff == led_pkg::OUT_CTL_OFF);
	wire wr_stat  = wr_fire & (aw_addr_ff == led_pkg::IRQ_STAT_OFF);
	wire wr_mask  = wr_fire & (aw_addr_ff == led_pkg::IRQ_MASK_OFF);
	wire wr_hit   = wr_cond | wr_inerr | wr_outc | wr_stat | wr_mask
	              | (aw_addr_ff == led_pkg::STATUS_OFF);
	// Write-one-to-clear, but a same-cycle event still sets the bit
	wire [led_pkg::IRQ_W-1:0] irq_clr = wr_stat ? wbits[led_pkg::IRQ_W-1:0] : '0;
	wire [led_pkg::IRQ_W-1:0] nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_evt;

	// Merge of written bytes into the old value
	function automatic logic [31:0] merge(input logic [31:0] old,
	                                      input logic [31:0] nw,
	                                      input logic [31:0] m);
		merge = (old & ~m) | (nw & m);
	endfunction
	// Merged words, one named result per written field so fields can be sliced
	wire [31:0] cond_m  = merge({26'h0, cond_ff}, w_data_ff, wmask);
	wire [31:0] inerr_m = merge({24'h0, in_err_ff}, w_data_ff, wmask);
	wire [31:0] outc_m  = merge({28'h0, out_cmd_ff}, w_data_ff, wmask);
	wire [31:0] terr_m  = merge({20'h0, out_terr_ff, 8'h0}, w_data_ff, wmask);
	wire [31:0] mask_m  = merge({29'h0, irq_mask_ff}, w_data_ff, wmask);

	// Software writable registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cond_ff     <= led_pkg::COND_RST;
			in_err_ff   <= '0;
			out_cmd_ff  <= '0;
			out_terr_ff <= '0;
			irq_mask_ff <= '0;
		end else begin
			if (wr_cond) begin
				cond_ff <= cond_m[led_pkg::COND_W-1:0];
			end
			if (wr_inerr) begin
				in_err_ff <= inerr_m[led_pkg::N_IN-1:0];
			end
			if (wr_outc) begin
				out_cmd_ff  <= outc_m[led_pkg::N_OUT-1:0];
				out_terr_ff <= terr_m[8 +: led_pkg::N_OUT];
			end
			if (wr_mask) begin
				irq_mask_ff <= mask_m[led_pkg::IRQ_W-1:0];
			end
		end
	end

	// Sticky event flags and the level interrupt
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_ff <= '0;
			irq_ff      <= 1'b0;
			crit_d_ff   <= 1'b0;
			repair_d_ff <= 1'b0;
			supply_d_ff <= 1'b0;
		end else begin
			irq_stat_ff <= nxt_irq_stat;
			irq_ff      <= |(nxt_irq_stat & irq_mask_ff);
			crit_d_ff   <= app_stop;
			repair_d_ff <= repair;
			supply_d_ff <= supply_ok;
		end
	end

	// Write channel: address and data taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff <= 1'b0;
			w_held_ff  <= 1'b0;
			aw_addr_ff <= '0;
			w_data_ff  <= '0;
			w_strb_ff  <= '0;
			awready_ff <= 1'b0;
			wready_ff  <= 1'b0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= led_pkg::RESP_OKAY;
		end else begin
			if (awvalid & awready_ff) begin
				aw_held_ff <= 1'b1;
				aw_addr_ff <= {awaddr[7:2], 2'b00};
			end
			if (wvalid & wready_ff) begin
				w_held_ff <= 1'b1;
				w_data_ff <= wdata;
				w_strb_ff <= wstrb;
			end
			awready_ff <= ~aw_held_ff & ~(awvalid & awready_ff) & ~bvalid_ff;
			wready_ff  <= ~w_held_ff & ~(wvalid & wready_ff) & ~bvalid_ff;
			if (wr_fire) begin
				aw_held_ff <= 1'b0;
				w_held_ff  <= 1'b0;
				bvalid_ff  <= 1'b1;
				bresp_ff   <= wr_hit ? led_pkg::RESP_OKAY : led_pkg::RESP_SLVERR;
			end else if (bvalid_ff & bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	// Read data mux
	wire [7:0] ra = {araddr[7:2], 2'b00};
	wire [31:0] status_word = {17'h0, app_stop, ms_red_ff, ms_green_ff,
	                           out_drive_ff, in_sync_ff};
	wire rd_hit = (ra == led_pkg::COND_OFF) | (ra == led_pkg::IN_ERR_OFF)
	            | (ra == led_pkg::OUT_CTL_OFF) | (ra == led_pkg::STATUS_OFF)
	            | (ra == led_pkg::IRQ_STAT_OFF) | (ra == led_pkg::IRQ_MASK_OFF);
	wire [31:0] rd_word =
		(ra == led_pkg::COND_OFF)     ? {26'h0, cond_ff} :
		(ra == led_pkg::IN_ERR_OFF)   ? {24'h0, in_err_ff} :
		(ra == led_pkg::OUT_CTL_OFF)  ? {20'h0, out_terr_ff, 4'h0, out_cmd_ff} :
		(ra == led_pkg::STATUS_OFF)   ? status_word :
		(ra == led_pkg::IRQ_STAT_OFF) ? {29'h0, irq_stat_ff} :
		(ra == led_pkg::IRQ_MASK_OFF) ? {29'h0, irq_mask_ff} : 32'h0;

	// Read channel: one read under way, answer one cycle after the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= '0;
			rresp_ff   <= led_pkg::RESP_OKAY;
		end else begin
			arready_ff <= ~rvalid_ff & ~ar_fire;
			if (ar_fire) begin
				rvalid_ff <= 1'b1;
				rdata_ff  <= rd_word;
				rresp_ff  <= rd_hit ? led_pkg::RESP_OKAY : led_pkg::RESP_SLVERR;
			end else if (rvalid_ff & rready) begin
				rvalid_ff <= 1'b0;
			end
		end
	end

	// Port drive
	assign awready   = awready_ff;
	assign wready    = wready_ff;
	assign bvalid    = bvalid_ff;
	assign bresp     = bresp_ff;
	assign arready   = arready_ff;
	assign rvalid    = rvalid_ff;
	assign rdata     = rdata_ff;
	assign rresp     = rresp_ff;
	assign out_drive = out_drive_ff;
	assign ms_red    = ms_red_ff;
	assign ms_green  = ms_green_ff;
	assign in_lamp   = in_lamp_ff;
	assign out_lamp  = out_lamp_ff;
	assign irq       = irq_ff;

	// Checks on lamp behaviour
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_crit_local;
		supply_ok && crit_here;
	endsequence
	sequence s_red_fast;
		ms_red_ff == $past(fl.blink_2hz) && !ms_green_ff;
	endsequence

	a_dark_no_supply: assert property (!supply_ok |=> !ms_red_ff && !ms_green_ff)
		else $error("module lamp lit with supply out of range");
	a_alt_red_green: assert property (
		supply_ok && !app_stop && !cfg_bad && repair
		|=> ms_red_ff != ms_green_ff && ms_red_ff == $past(fl.blink_1hz))
		else $error("alternating flash wrong");
	a_green_flash: assert property (
		supply_ok && !app_stop && !cfg_bad && !repair && !running
		|=> !ms_red_ff && ms_green_ff == $past(fl.blink_1hz))
		else $error("stop state green flash wrong");
	a_steady_green_cause: assert property (
		ms_green_ff && !$past(fl.blink_1hz) && !$past(repair)
		|-> $past(running) && $past(window_ok) && $past(supply_ok))
		else $error("steady green without run and good supply");
	a_local_crit: assert property (s_crit_local |=> s_red_fast and out_drive_ff == '0)
		else $error("local critical error indication wrong");
	a_remote_crit: assert property (
		supply_ok && !crit_here && crit_away |=> ms_red_ff && !ms_green_ff ##0
		out_drive_ff == '0)
		else $error("remote critical error indication wrong");
	a_input_plain: assert property (
		in_err_ff == '0 |=> in_lamp_ff == $past(in_sync_ff))
		else $error("input lamp does not follow level");
	a_input_err_phase: assert property (
		in_err_ff[0] |=> in_lamp_ff[0] == ($past(in_sync_ff[0]) ^ $past(fl.blink_1hz)))
		else $error("input error flash phase wrong");
	a_output_lamp: assert property (
		1'b1 |=> out_lamp_ff == (($past(out_terr_ff) & {led_pkg::N_OUT{$past(fl.blink_1hz)}})
		| ($past(out_drive_ff) & ~$past(out_terr_ff))))
		else $error("output lamp wrong");
	a_blink_aligned: assert property ($changed(fl.blink_1hz) |-> $changed(fl.blink_2hz))
		else $error("1 Hz edge not on a 2 Hz edge");
endmodule
`default_nettype wire

//--- verification/lamp_observer.sv
// Operator-side view of the module lamp: counts turn-ons and red lit time
`timescale 1ns/1ps
`default_nettype none
module lamp_observer (
	// Clock and window restart
	input  wire logic aclk,
	input  wire logic clr,
	// Module lamp colours
	input  wire logic red,
	input  wire logic green,
	// Counts since the last restart
	output var int    red_rise,
	output var int    green_rise,
	output var int    red_high
);
	logic red_ff;	// Red level one edge ago
	logic green_ff;	// Green level one edge ago
	// An eye judges flashing by turn-ons per window, so count rises, not levels
	always_ff @(posedge aclk) begin
		red_ff <= red;
		green_ff <= green;
		if (clr) begin
			red_rise <= 0;
			green_rise <= 0;
			red_high <= 0;
		end else begin
			red_rise <= red_rise + int'(red && !red_ff);
			green_rise <= green_rise + int'(green && !green_ff);
			red_high <= red_high + int'(red);
		end
	end
endmodule
`default_nettype wire

//--- verification/status_led_driver_bench.sv
// Self-checking bench for the status lamp driver
`timescale 1ns/1ps
`default_nettype none
module status_led_driver_bench;
	// Clock, reset and bus drive
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'hf;	// Full words only
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic [7:0]  in_level = 8'h00;
	// Design answers
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [3:0]  out_drive, out_lamp;
	logic [7:0]  in_lamp;
	logic        ms_red, ms_green, irq;
	// Observer and bookkeeping
	logic        clr = 1'b0;
	int          red_rise, green_rise, red_high;
	int          mismatches = 0;
	int          samples_checked = 0;
	logic [31:0] d;
	logic [1:0]  r;

	// Short quarter keeps a 1 Hz period at 16 cycles
	status_led_driver #(.QUARTER(25'h0000004)) uut (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .in_level(in_level), .out_drive(out_drive), .ms_red(ms_red),
		.ms_green(ms_green), .in_lamp(in_lamp), .out_lamp(out_lamp), .irq(irq));
	lamp_observer eye (.aclk(aclk), .clr(clr), .red(ms_red), .green(ms_green),
		.red_rise(red_rise), .green_rise(green_rise), .red_high(red_high));

	// Free-running clock
	always #5 aclk = ~aclk;

	// Single comparison point
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask

	// Verdict and end of run
	task close_out;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Bus write: address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
		logic ad, wd;
		ad = 1'b0;
		wd = 1'b0;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge aclk);
			if (awvalid && awready) begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				wd = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!bvalid);
		resp = bresp;
		bready <= 1'b0;
		// One edge passes so the next request never reassigns in this step
		@(posedge aclk);
	endtask

	// Bus read: one word, data taken at the edge rvalid is seen
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		v = rdata;
		resp = rresp;
		rready <= 1'b0;
		// One edge passes so the next request never reassigns in this step
		@(posedge aclk);
	endtask

	// Set conditions, then count lamp turn-ons over four 1 Hz periods
	task automatic mode(input logic [5:0] c, input int rr, input int gr);
		wr(led_pkg::COND_OFF, {26'h0, c}, r);
		repeat (4) @(posedge aclk);
		clr <= 1'b1;
		@(posedge aclk);
		clr <= 1'b0;
		repeat (65) @(posedge aclk);
		check(32'(red_rise), 32'(rr));
		check(32'(green_rise), 32'(gr));
	endtask

	// Reset values and refused addresses
	task t_regs;
		check(32'({ms_red, ms_green}), 32'h0);
		rd(led_pkg::COND_OFF, d, r);
		check(d, 32'h0);
		check(32'(r), 32'(led_pkg::RESP_OKAY));
		rd(8'h40, d, r);
		check(32'(r), 32'(led_pkg::RESP_SLVERR));
		wr(8'h40, 32'h1, r);
		check(32'(r), 32'(led_pkg::RESP_SLVERR));
		wr(led_pkg::IRQ_STAT_OFF, 32'h7, r);
		$display("test regs done");
	endtask

	// Steady and slow-flash module lamp states
	task t_module;
		mode(6'h05, 0, 0);
		check(32'({ms_red, ms_green}), 32'h0);
		mode(6'h07, 0, 0);
		check(32'({ms_red, ms_green}), 32'h1);
		mode(6'h06, 0, 4);
		mode(6'h03, 0, 4);
		check(32'(red_high), 32'h0);
		mode(6'h0f, 4, 0);
		check(32'(red_high), 32'h20);
		$display("test module lamp done");
	endtask

	// Repairable errors: alternate colours and channel phases
	task t_repair;
		in_level <= 8'h02;
		wr(led_pkg::OUT_CTL_OFF, 32'h0000_0405, r);
		wr(led_pkg::IN_ERR_OFF, 32'h0000_0003, r);
		mode(6'h07, 4, 4);
		check(32'(red_high), 32'h20);
		repeat (32) begin
			@(posedge aclk);
			check(32'(ms_green), 32'(!ms_red));
			check(32'(in_lamp[0]), 32'(ms_red));
			check(32'(in_lamp[1]), 32'(ms_green));
			check(32'(out_lamp), {28'h0, 1'b0, ms_red, 2'b01});
			check(32'(in_lamp[7:2]), 32'h0);
		end
		$display("test repairable done");
	endtask

	// Plain input levels with no error pending
	task t_inputs;
		wr(led_pkg::IN_ERR_OFF, 32'h0, r);
		in_level <= 8'ha5;
		repeat (6) @(posedge aclk);
		check(32'(in_lamp), 32'h0000_00a5);
		check(32'(out_drive), 32'h5);
		rd(led_pkg::STATUS_OFF, d, r);
		check(32'(d[7:0]), 32'h0000_00a5);
		$display("test inputs done");
	endtask

	// Critical errors here and elsewhere, with the interrupt
	task t_crit;
		wr(led_pkg::IRQ_MASK_OFF, 32'h1, r);
		mode(6'h17, 8, 0);
		check(32'(red_high), 32'h20);
		check(32'(out_drive), 32'h0);
		check(32'(irq), 32'h1);
		rd(led_pkg::STATUS_OFF, d, r);
		check(32'(d[14]), 32'h1);
		wr(led_pkg::IRQ_STAT_OFF, 32'h1, r);
		repeat (3) @(posedge aclk);
		check(32'(irq), 32'h0);
		// Critical flag cleared, repairable flag from earlier still sticky
		rd(led_pkg::IRQ_STAT_OFF, d, r);
		check(d, 32'h2);
		mode(6'h27, 0, 0);
		check(32'({ms_red, ms_green}), 32'h2);
		check(32'(out_drive), 32'h0);
		$display("test critical done");
	endtask

	// Main sequence
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs;
		t_module;
		t_repair;
		t_inputs;
		t_crit;
		close_out;
	end

	// Watchdog: the whole sequence needs well under 3000 cycles
	initial begin
		#200us;
		mismatches++;
		close_out;
	end
endmodule
`default_nettype wire
